/* srw_defs.vh */
// Constants for the slot reset and wake sequencer, card side.
// Assumes a 200 MHz core clock; included by bare name.
`ifndef SRW_DEFS_VH
`define SRW_DEFS_VH
`define SRW_CLK_PERIOD_PS      32'd5000
`define SRW_WAKE_SETTLE_NS     32'd100
`define SRW_WAKE_SETTLE_CYC    ((`SRW_WAKE_SETTLE_NS * 32'd1000 + `SRW_CLK_PERIOD_PS - 32'd1) / `SRW_CLK_PERIOD_PS)
`define SRW_ASPM_RESET_VAL     2'h0
`define SRW_PSTATE_D0          2'h0
`define SRW_PSTATE_D3          2'h3
`define SRW_BEACON_HALF_CYC    8'h10
`endif

/* srw_sync.v */
// Two-stage synchroniser for asynchronous pins.
// Assumes one clock; reset value is a parameter constant.
`timescale 1ns/1ps
module srw_sync #(
  parameter       WIDTH    = 1,
  parameter [0:0] RST_VAL  = 1'b1
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] d_in,
  output wire [WIDTH-1:0] q_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= {WIDTH{RST_VAL}};
      sync_q <= {WIDTH{RST_VAL}};
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end
  assign q_out = sync_q;
endmodule

/* srw_sequencer.v */
// What the document asks of the card and the system around it
// RULE1: System holds reset through power-to-reset delay
// RULE2: System starts reference clock before reset release
// RULE3: Card logic held in reset while asserted
// RULE4: Link power field zero after power-up, resume
// RULE5: System asserts reset before removing power
// RULE6: Surprise loss: reset within power-fail delay
// RULE7: Suspend needs D3hot and L2 first
// RULE8: Link idle before managed reset assertion
// RULE9: System stops clock only after reset
// RULE10: Reset stays active minimum time
// RULE11: Wake restores power, then power-up sequence
// RULE12: Card pulls open-drain wake low to request
// RULE13: Wake only all-D3 with event enable
// RULE14: Receiver never turns wake into interrupt
// RULE15: Wake edges asynchronous to all clocks
// RULE16: Flush/fill hint card samples wake input
// RULE17: Never pull wake low unintentionally
// RULE18: Wake indeterminate 100 ns after release
// RULE19: Hot-plug isolates wake during insertion
// RULE20: Wake-capable card can send beacon
// RULE21: Synchronise reset and wake, async assert
//
// Card-side reset and wake sequencer.
// Assumes clk_in runs from auxiliary power; fundamental reset and wake pin are async.
`timescale 1ns/1ps
`include "srw_defs.vh"
module srw_sequencer #(
  parameter NFUNC = 2
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             fundamental_reset_n_in,
  input  wire             cold_resume_in,
  input  wire [2*NFUNC-1:0] func_pstate_in,
  input  wire [NFUNC-1:0] power_event_enable_in,
  input  wire [NFUNC-1:0] wake_pending_in,
  input  wire             link_l2_in,
  input  wire             link_idle_in,
  input  wire             beacon_enable_in,
  input  wire             aspm_wr_in,
  input  wire [1:0]       aspm_wdata_in,
  input  wire             wake_pin_in,
  output wire             wake_pin_out,
  output wire             wake_pin_oe_out,
  output wire             func_rst_n_out,
  output reg  [1:0]       aspm_ctrl_out,
  output reg              wake_active_out,
  output reg              obff_hint_out,
  output reg              obff_valid_out,
  output reg              beacon_out,
  output reg              link_order_err_out
);
  localparam ST_RESET = 4'h1;
  localparam ST_RUN   = 4'h2;
  localparam ST_WAKE  = 4'h4;
  localparam ST_HOLD  = 4'h8;
  // Settle count is computed at 32 bits and cut to the counter width on purpose
  localparam [31:0] SETTLE_W = `SRW_WAKE_SETTLE_CYC;
  localparam [7:0]  SETTLE   = SETTLE_W[7:0];

  // All functions in D3 (hot or cold)
  function all_d3;
    input [2*NFUNC-1:0] ps;
    integer i;
    begin
      all_d3 = 1'b1;
      for (i = 0; i < NFUNC; i = i + 1) begin
        if (ps[2*i +: 2] != `SRW_PSTATE_D3) all_d3 = 1'b0;
      end
    end
  endfunction

  wire       core_rst_n;
  wire       fres_n_s;
  wire       wake_s;
  reg        rst_m_q;
  reg        rst_s_q;
  reg        func_rst_q;
  reg  [3:0] state_q;
  reg  [3:0] state_d;
  reg  [7:0] settle_q;
  reg  [7:0] beacon_cnt_q;
  reg        fres_prev_q;
  wire [NFUNC-1:0] fn_req;

  // Core reset: async assert, sync release
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  assign core_rst_n = rst_s_q;

  srw_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_fres_sync (
    .clk_in   (clk_in),
    .rst_n_in (core_rst_n),
    .d_in     (fundamental_reset_n_in),
    .q_out    (fres_n_s)
  ); // [RULE21]
  srw_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_wake (
    .clk_in   (clk_in),
    .rst_n_in (core_rst_n),
    .d_in     (wake_pin_in),
    .q_out    (wake_s)
  ); // [RULE15] [RULE21]

  // Function reset asserts straight from the pin, releases via the synchroniser
  always @(posedge clk_in or negedge fundamental_reset_n_in) begin
    if (!fundamental_reset_n_in) func_rst_q <= 1'b0; // [RULE3]
    else                         func_rst_q <= fres_n_s & core_rst_n; // [RULE21]
  end
  assign func_rst_n_out = func_rst_q & core_rst_n; // [RULE3]

  genvar g;
  generate
    for (g = 0; g < NFUNC; g = g + 1) begin : g_req
      assign fn_req[g] = power_event_enable_in[g] & wake_pending_in[g];
    end
  endgenerate

  wire wake_ok = all_d3(func_pstate_in) & (|power_event_enable_in); // [RULE13]
  wire wake_go = wake_ok & (|fn_req);
  // A request raised while the fundamental reset is low goes straight to WAKE
  wire wake_in_reset = (state_q == ST_RESET) && !fres_n_s && wake_go; // [RULE11]
  // The line is only an input hint while we run out of reset and do not pull it
  wire hint_ok = (state_q == ST_RUN) && fres_n_s;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RESET: if (fres_n_s) state_d = ST_RUN;
      ST_RUN:   if (wake_go) state_d = ST_WAKE;
      ST_WAKE:  if (!wake_go || (fres_n_s && !wake_ok)) state_d = ST_HOLD;
      ST_HOLD:  if (settle_q == 8'h00) state_d = ST_RUN; // [RULE18]
      default:  state_d = ST_RESET;
    endcase
  end

  // Sequencing state and the settle count after a released request
  always @(posedge clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state_q  <= ST_RESET;
      settle_q <= 8'h00;
    end else begin
      // Wake state survives the fundamental reset: card may need to keep asking for power
      if (wake_in_reset) begin
        state_q <= ST_WAKE; // [RULE11]
      end else begin
        state_q <= state_d;
      end
      if (state_d == ST_HOLD && state_q != ST_HOLD) begin
        settle_q <= SETTLE; // [RULE18]
      end else if (settle_q != 8'h00) begin
        settle_q <= settle_q - 8'h01;
      end
    end
  end

  // Request level follows the same next state as the sequencer
  always @(posedge clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      wake_active_out <= 1'b0;
    end else begin
      wake_active_out <= wake_in_reset || (state_d == ST_WAKE); // [RULE12]
    end
  end

  // Link power field: software value only while out of reset and not resuming cold
  always @(posedge clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      aspm_ctrl_out <= `SRW_ASPM_RESET_VAL;
    end else if (!fres_n_s || cold_resume_in) begin
      aspm_ctrl_out <= `SRW_ASPM_RESET_VAL; // [RULE4]
    end else if (aspm_wr_in) begin
      aspm_ctrl_out <= aspm_wdata_in;
    end
  end

  // Hint sampled only when we are not driving and the line has settled
  always @(posedge clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      obff_hint_out  <= 1'b1;
      obff_valid_out <= 1'b0;
    end else begin
      obff_valid_out <= hint_ok; // [RULE16] [RULE18]
      if (hint_ok) begin
        obff_hint_out <= wake_s; // [RULE16]
      end
    end
  end

  // Beacon toggles while requesting wake with link in L2
  always @(posedge clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      beacon_out   <= 1'b0;
      beacon_cnt_q <= 8'h00;
    end else if (state_q == ST_WAKE && beacon_enable_in && link_l2_in) begin // [RULE20] [RULE7]
      if (beacon_cnt_q == 8'h00) begin
        beacon_cnt_q <= `SRW_BEACON_HALF_CYC;
        beacon_out   <= ~beacon_out;
      end else begin
        beacon_cnt_q <= beacon_cnt_q - 8'h01;
      end
    end else begin
      beacon_cnt_q <= 8'h00;
      beacon_out   <= 1'b0;
    end
  end

  // Flag a reset edge that arrived while the link was still active; set and
  // clear need opposite reset levels, so they never meet in one cycle
  always @(posedge clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      fres_prev_q        <= 1'b0;
      link_order_err_out <= 1'b0;
    end else begin
      fres_prev_q <= fres_n_s;
      if (fres_prev_q && !fres_n_s && !link_idle_in) begin
        link_order_err_out <= 1'b1; // [RULE8]
      end else if (fres_n_s && !fres_prev_q) begin
        link_order_err_out <= 1'b0;
      end
    end
  end

  // Open drain: only ever drive low, and only during a deliberate request
  assign wake_pin_out    = 1'b0; // [RULE12]
  assign wake_pin_oe_out = (state_q == ST_WAKE) & wake_go; // [RULE17] [RULE13]
endmodule

/* srw_checker.sv */
// Port assertions for the card-side reset and wake sequencer.
// Bound into srw_sequencer; one clock, reset rst_n_in.
`timescale 1ns/1ps
module srw_checker #(parameter NFUNC = 2) (
  input wire               clk_in,
  input wire               rst_n_in,
  input wire               fundamental_reset_n_in,
  input wire               cold_resume_in,
  input wire [2*NFUNC-1:0] func_pstate_in,
  input wire [NFUNC-1:0]   power_event_enable_in,
  input wire [NFUNC-1:0]   wake_pending_in,
  input wire               link_l2_in,
  input wire               beacon_enable_in,
  input wire               wake_pin_out,
  input wire               wake_pin_oe_out,
  input wire               func_rst_n_out,
  input wire [1:0]         aspm_ctrl_out,
  input wire               beacon_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Line must stay quiet while it floats back up
  sequence s_quiet;
    !wake_pin_oe_out [*8];
  endsequence
  rst_hold_a: assert property (!fundamental_reset_n_in |-> !func_rst_n_out)
    else $error("functions out of reset while pin low");
  rst_sync_a: assert property ($rose(fundamental_reset_n_in) |=> !func_rst_n_out)
    else $error("reset release not synchronised");
  aspm_clear_a: assert property (cold_resume_in |=> aspm_ctrl_out == 2'h0)
    else $error("link power field not cleared");
  drain_only_a: assert property (wake_pin_out == 1'b0)
    else $error("wake pin driven high");
  wake_cond_a: assert property (wake_pin_oe_out |->
    func_pstate_in == {NFUNC{2'h3}} && |power_event_enable_in)
    else $error("wake outside all-D3 with enable");
  wake_intent_a: assert property (wake_pin_oe_out |-> |wake_pending_in)
    else $error("wake pulled without request");
  wake_settle_a: assert property ($fell(wake_pin_oe_out) |=> s_quiet)
    else $error("wake re-pulled during settle");
  beacon_gate_a: assert property ($rose(beacon_out) |->
    $past(link_l2_in && beacon_enable_in))
    else $error("beacon outside L2 with enable");
endmodule
bind srw_sequencer srw_checker #(.NFUNC(NFUNC)) srw_checker_i (.*);

/* srw_psys.sv */
// System power manager model: slot power, fundamental reset, wake input.
// Shares the bench clock; DLY stands in for the long power-to-reset delay.
`timescale 1ns/1ps
module srw_psys #(parameter DLY = 40) (
  input  wire clk_in,
  input  wire pwr_in,
  input  wire wake_n_in,
  output reg  prst_n_out
);
  reg on_q = 1'b0;
  reg pwr_q = 1'b0;
  int cnt_q = 0;
  initial prst_n_out = 1'b0;
  always @(posedge clk_in) begin
    pwr_q <= pwr_in;
    // Wake only restores power, no interrupt path
    if (!pwr_in && pwr_q) on_q <= 1'b0;
    else if (pwr_in || !wake_n_in) on_q <= 1'b1;
    if (!on_q || (!pwr_in && pwr_q)) begin
      prst_n_out <= 1'b0;
      cnt_q <= 0;
    end else if (cnt_q == DLY) prst_n_out <= 1'b1;
    else cnt_q <= cnt_q + 1;
  end
endmodule

/* srw_sequencer_test.sv */
// Self-checking bench for srw_sequencer with the power manager model.
// Inputs change at the falling edge; wake line has a pull-up.
`timescale 1ns/1ps
module srw_sequencer_test;
  logic clk_in = 0, rst_n_in = 0, cold = 0, l2 = 0, idle = 1, bcn = 0, awr = 0, pwr = 0;
  logic [3:0] ps = 0;
  logic [1:0] en = 0, pend = 0, adat = 0;
  logic       b;
  wire        prst_n, oe, wpo, frn, act, hint, hv, bo, lerr;
  wire [1:0]  aspm;
  wire        wake_n = oe ? 1'b0 : 1'b1; // Pull-up keeps it inactive otherwise
  int error_cnt = 0, check_count = 0, cyc = 0;
  srw_psys srw_psys_i (.clk_in(clk_in), .pwr_in(pwr), .wake_n_in(wake_n), .prst_n_out(prst_n));
  srw_sequencer srw_sequencer_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .fundamental_reset_n_in(prst_n), .cold_resume_in(cold), .func_pstate_in(ps),
    .power_event_enable_in(en), .wake_pending_in(pend), .link_l2_in(l2),
    .link_idle_in(idle), .beacon_enable_in(bcn), .aspm_wr_in(awr), .aspm_wdata_in(adat),
    .wake_pin_in(wake_n), .wake_pin_out(wpo), .wake_pin_oe_out(oe), .func_rst_n_out(frn),
    .aspm_ctrl_out(aspm), .wake_active_out(act), .obff_hint_out(hint),
    .obff_valid_out(hv), .beacon_out(bo), .link_order_err_out(lerr));
  initial forever #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task report_and_stop;
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(string n, logic [1:0] s, logic [1:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task cy(int n);
    repeat (n) @(negedge clk_in);
  endtask
  task wait_run;
    for (int i = 0; i < 200 && frn !== 1'b1; i++) cy(1);
    chk("frn", {1'b0, frn}, 2'h1);
  endtask
  task t_aspm;
    chk("frn", {1'b0, frn}, 2'h0);
    chk("aspm", aspm, 2'h0);
    pwr = 1;
    wait_run();
    cy(2);
    chk("hv", {1'b0, hv}, 2'h1);
    chk("hint", {1'b0, hint}, 2'h1);
    adat = 2'h2; awr = 1; cy(1); awr = 0; cy(2);
    chk("aspm", aspm, 2'h2);
    cold = 1; cy(2);
    chk("aspm", aspm, 2'h0);
    adat = 2'h3; awr = 1; cy(1); awr = 0; cy(2); cold = 0;
    chk("aspm", aspm, 2'h0);
  endtask
  task t_refuse;
    ps = 4'h3; en = 2'h1; pend = 2'h1; cy(6);
    chk("oe", {1'b0, oe}, 2'h0);
    ps = 4'hf; en = 2'h0; cy(6);
    chk("oe", {1'b0, oe}, 2'h0);
    pend = 2'h0;
  endtask
  task t_wake;
    en = 2'h2; pend = 2'h2; cy(3);
    chk("oe", {1'b0, oe}, 2'h1);
    chk("act", {1'b0, act}, 2'h1);
    chk("hv", {1'b0, hv}, 2'h0);
    pend = 2'h0; cy(1);
    chk("oe", {1'b0, oe}, 2'h0);
    pend = 2'h2; cy(8);
    chk("oe", {1'b0, oe}, 2'h0);
    cy(20);
    chk("oe", {1'b0, oe}, 2'h1);
    pend = 2'h0; cy(25);
  endtask
  task t_susp;
    idle = 0; pwr = 0; cy(6);
    chk("frn", {1'b0, frn}, 2'h0);
    chk("lerr", {1'b0, lerr}, 2'h1);
    idle = 1; l2 = 1; bcn = 1; pend = 2'h2; cy(3);
    b = bo; cy(17);
    chk("beacon", {1'b0, bo}, {1'b0, ~b});
    pend = 2'h0;
    wait_run();
    chk("lerr", {1'b0, lerr}, 2'h0);
  endtask
  initial begin
    cy(12);
    rst_n_in = 1;
    cy(3);
    t_aspm();
    t_refuse();
    t_wake();
    t_susp();
    report_and_stop();
  end
endmodule
